// ### hw/adss_regs.sv
// system settings register bank: clock, serial output and serial input setup
//
// Behaviour
// R01: crystal divider bits 9..8 set oscillator to sample-rate ratio, DAC at 64fs.
// R02: divider codes 00..11 give 128/256/384/512 fs, ratios 1:2/1:4/1:6/1:8.
// R03: crystal divider field is write-only; reads return zero.
// R04: prescaler bits 3..2 set prescaler ratio, effective only in synthesizer mode.
// R05: prescaler codes give 1:36, 1:625, 1:640, 1:1125.
// R06: clock source bit 1 high selects crystal and drives clock output pin.
// R07: bit 0 enables frequency synthesizer mode, reset value zero.
// R08: mute bypass bit 8 high keeps output unmuted; low mutes on lock loss.
// R09: output format bits 2..0 of register 1 select serial output format.
// R10: output codes: I2S, LSB 16/18/20/24, MSB, two reserved.
// R11: input format bits 2..0 of register 2 select serial input format.
// R12: input codes decode like output codes.
// R13: all defined fields reset to zero.
// R14: software writes zero to reserved bits and avoids reserved format codes.
// R15: fields are flip-flops loaded on a write; reserved bit writes ignored.
`timescale 1ns/100ps
`default_nettype none
`include "adss_defs.svh"
module adss_regs (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [`ADSS_ADDR_W-1:0]    addr_i,
  input  wire logic [`ADSS_DATA_W-1:0]    wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [`ADSS_DATA_W-1:0]    rdata_o,
  input  wire logic                       lock_lost_i,
  input  wire logic                       non_pcm_i,
  output logic                            out_mute_o,
  output logic                            mute_bypass_o,
  output adss_pkg::adss_xdiv_t            crystal_divider_sel_o,
  output adss_pkg::adss_presc_t           prescaler_ratio_sel_o,
  output adss_pkg::adss_clk_cfg_t         clk_cfg_o,
  output adss_pkg::adss_fmt_cfg_t         out_fmt_o,
  output adss_pkg::adss_fmt_cfg_t         in_fmt_o
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0] xdiv_q;
  logic [1:0] presc_q;
  logic       clksrc_q;
  logic       synth_q;
  logic       mutebyp_q;
  logic [2:0] ofmt_q;
  logic [2:0] ifmt_q;
  logic       lock_s1_q;
  logic       lock_s2_q;
  logic       lock_s3_q;
  logic       lock_q;
  logic       npcm_s1_q;
  logic       npcm_s2_q;
  logic       npcm_s3_q;
  logic       npcm_q;

  function automatic logic hit(input logic [`ADSS_ADDR_W-1:0] a,
                               input logic [`ADSS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      xdiv_q   <= `ADSS_XDIV_RST; // R13
      presc_q  <= `ADSS_PRESC_RST; // R13
      clksrc_q <= 1'b0;
      synth_q  <= 1'b0; // R07
    end
    else if (wr_i && hit(addr_i, `ADSS_OFF_CLOCK))
    begin
      xdiv_q   <= wdata_i[`ADSS_XDIV_HI:`ADSS_XDIV_LO]; // R15
      presc_q  <= wdata_i[`ADSS_PRESC_HI:`ADSS_PRESC_LO];
      clksrc_q <= wdata_i[`ADSS_CLKSRC_BIT];
      synth_q  <= wdata_i[`ADSS_SYNTH_BIT]; // R07
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mutebyp_q <= 1'b0; // R13
      ofmt_q    <= `ADSS_FMT_RST;
    end
    else if (wr_i && hit(addr_i, `ADSS_OFF_SER_OUT))
    begin
      mutebyp_q <= wdata_i[`ADSS_MUTEBYP_BIT]; // R15
      ofmt_q    <= wdata_i[`ADSS_FMT_HI:`ADSS_FMT_LO]; // R09
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ifmt_q <= `ADSS_FMT_RST; // R13
    else if (wr_i && hit(addr_i, `ADSS_OFF_SER_IN))
      ifmt_q <= wdata_i[`ADSS_FMT_HI:`ADSS_FMT_LO]; // R11
  end

  ////////////////////////////////////////////////////////////////////////////
  // reads: all registers write-only, data is zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= `ADSS_READ_ZERO;
    else if (rd_i)
      rdata_o <= `ADSS_READ_ZERO; // R03
    else
      rdata_o <= `ADSS_READ_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock and non-pcm pin synchronisers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_s3_q <= 1'b0;
      lock_q    <= 1'b0;
      npcm_s1_q <= 1'b0;
      npcm_s2_q <= 1'b0;
      npcm_s3_q <= 1'b0;
      npcm_q    <= 1'b0;
    end
    else
    begin
      lock_s1_q <= lock_lost_i;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
      if (lock_s2_q == lock_s3_q)
        lock_q <= lock_s3_q;
      npcm_s1_q <= non_pcm_i;
      npcm_s2_q <= npcm_s1_q;
      npcm_s3_q <= npcm_s2_q;
      if (npcm_s2_q == npcm_s3_q)
        npcm_q <= npcm_s3_q;
    end
  end

  // mute applies on lock loss unless bypassed
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      out_mute_o <= 1'b0;
    else
      out_mute_o <= !mutebyp_q && lock_q; // R08
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock configuration outputs
  always_comb
  begin
    clk_cfg_o                 = '0;
    clk_cfg_o.xtal_half_ratio = {2'b00, xdiv_q} + 4'h1; // R01 R02
    case (presc_q)
      2'b00: clk_cfg_o.prescaler_ratio = `ADSS_PRESC_36; // R05
      2'b01: clk_cfg_o.prescaler_ratio = `ADSS_PRESC_625;
      2'b10: clk_cfg_o.prescaler_ratio = `ADSS_PRESC_640;
      default: clk_cfg_o.prescaler_ratio = `ADSS_PRESC_1125;
    endcase
    if (!synth_q)
      clk_cfg_o.prescaler_ratio = 11'h000; // R04
    clk_cfg_o.synth_mode_en       = synth_q; // R07
    clk_cfg_o.clock_source_select = clksrc_q; // R06
    clk_cfg_o.clock_output_en     = clksrc_q; // R06
  end

  assign crystal_divider_sel_o = adss_pkg::adss_xdiv_t'(xdiv_q); // R01
  assign prescaler_ratio_sel_o = adss_pkg::adss_presc_t'(presc_q); // R04
  assign mute_bypass_o         = mutebyp_q; // R08

  ////////////////////////////////////////////////////////////////////////////
  // format decoders
  adss_fmt_decode u_out_fmt (
    .code_i (ofmt_q),
    .cfg_o  (out_fmt_o) // R10
  );

  adss_fmt_decode u_in_fmt (
    .code_i (ifmt_q),
    .cfg_o  (in_fmt_o) // R12
  );
endmodule : adss_regs
`default_nettype wire

// ### hw/adss_defs.svh
// offsets, field positions and reset values of the system settings bank
`ifndef ADSS_DEFS_SVH
`define ADSS_DEFS_SVH
`define ADSS_ADDR_W          7
`define ADSS_DATA_W          16
`define ADSS_OFF_CLOCK       7'h00
`define ADSS_OFF_SER_OUT     7'h01
`define ADSS_OFF_SER_IN      7'h02
`define ADSS_XDIV_HI         9
`define ADSS_XDIV_LO         8
`define ADSS_PRESC_HI        3
`define ADSS_PRESC_LO        2
`define ADSS_CLKSRC_BIT      1
`define ADSS_SYNTH_BIT       0
`define ADSS_MUTEBYP_BIT     8
`define ADSS_FMT_HI          2
`define ADSS_FMT_LO          0
`define ADSS_XDIV_RST        2'h0
`define ADSS_PRESC_RST       2'h0
`define ADSS_FMT_RST         3'h0
`define ADSS_READ_ZERO       16'h0000
`define ADSS_PRESC_36        11'h024
`define ADSS_PRESC_625       11'h271
`define ADSS_PRESC_640       11'h280
`define ADSS_PRESC_1125      11'h465
`endif

// ### hw/adss_pkg.sv
// types of the system settings bank
package adss_pkg;
  typedef enum logic [1:0] {
    ADSS_XDIV_128FS = 2'b00,
    ADSS_XDIV_256FS = 2'b01,
    ADSS_XDIV_384FS = 2'b10,
    ADSS_XDIV_512FS = 2'b11
  } adss_xdiv_t;

  typedef enum logic [1:0] {
    ADSS_PRESC_R36   = 2'b00,
    ADSS_PRESC_R625  = 2'b01,
    ADSS_PRESC_R640  = 2'b10,
    ADSS_PRESC_R1125 = 2'b11
  } adss_presc_t;

  typedef enum logic [2:0] {
    ADSS_FMT_I2S     = 3'b000,
    ADSS_FMT_LSB16   = 3'b001,
    ADSS_FMT_LSB18   = 3'b010,
    ADSS_FMT_LSB20   = 3'b011,
    ADSS_FMT_LSB24   = 3'b100,
    ADSS_FMT_MSB     = 3'b101,
    ADSS_FMT_RSVD6   = 3'b110,
    ADSS_FMT_RSVD7   = 3'b111
  } adss_fmt_t;

  typedef struct packed {
    logic [3:0]  xtal_half_ratio;
    logic [10:0] prescaler_ratio;
    logic        synth_mode_en;
    logic        clock_source_select;
    logic        clock_output_en;
  } adss_clk_cfg_t;

  typedef struct packed {
    adss_fmt_t   fmt;
    logic [4:0]  word_bits;
    logic        lsb_justified;
    logic        msb_justified;
    logic        reserved_code;
  } adss_fmt_cfg_t;
endpackage : adss_pkg

// ### hw/adss_fmt_decode.sv
// serial audio format code decoder
`timescale 1ns/100ps
`default_nettype none
`include "adss_defs.svh"
module adss_fmt_decode (
  input  wire logic [2:0]            code_i,
  output adss_pkg::adss_fmt_cfg_t    cfg_o
);
  always_comb
  begin
    cfg_o               = '0;
    cfg_o.fmt           = adss_pkg::adss_fmt_t'(code_i);
    case (code_i)
      3'h0: cfg_o.word_bits = 5'h00;
      3'h1: cfg_o.word_bits = 5'h10;
      3'h2: cfg_o.word_bits = 5'h12;
      3'h3: cfg_o.word_bits = 5'h14;
      3'h4: cfg_o.word_bits = 5'h18;
      default: cfg_o.word_bits = 5'h00;
    endcase
    cfg_o.lsb_justified = (code_i >= 3'h1) && (code_i <= 3'h4);
    cfg_o.msb_justified = (code_i == 3'h5);
    cfg_o.reserved_code = (code_i[2:1] == 2'b11);
  end
endmodule : adss_fmt_decode
`default_nettype wire

// ### test/adss_regs_chk.sv
// assertion checker of the system settings register bank
`timescale 1ns/100ps
`default_nettype none
`include "adss_defs.svh"
module adss_regs_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  input wire logic [6:0]              addr_i,
  input wire logic [15:0]             wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [15:0]             rdata_o,
  input wire logic                    lock_lost_i,
  input wire logic                    non_pcm_i,
  input wire logic                    out_mute_o,
  input wire logic                    mute_bypass_o,
  input wire adss_pkg::adss_xdiv_t    crystal_divider_sel_o,
  input wire adss_pkg::adss_presc_t   prescaler_ratio_sel_o,
  input wire adss_pkg::adss_clk_cfg_t clk_cfg_o,
  input wire adss_pkg::adss_fmt_cfg_t out_fmt_o,
  input wire adss_pkg::adss_fmt_cfg_t in_fmt_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic w0, w1, w2;
  assign w0 = wr_i && addr_i == 7'h00;
  assign w1 = wr_i && addr_i == 7'h01;
  assign w2 = wr_i && addr_i == 7'h02;
  ////////////////////////////////////////////////////////////////
  a_xdiv_write: assert property (w0 |=> crystal_divider_sel_o == $past(wdata_i[9:8]))
    else $error("divider");
  a_xdiv_hold: assert property (!w0 |=> $stable(crystal_divider_sel_o))
    else $error("divider hold");
  a_presc_write: assert property (w0 |=> prescaler_ratio_sel_o == $past(wdata_i[3:2]))
    else $error("prescaler");
  a_presc_off: assert property (!clk_cfg_o.synth_mode_en |-> clk_cfg_o.prescaler_ratio == 0)
    else $error("prescaler off");
  a_src_write: assert property (w0 |=> clk_cfg_o.clock_output_en == $past(wdata_i[1]))
    else $error("source");
  a_synth_write: assert property (w0 |=> clk_cfg_o.synth_mode_en == $past(wdata_i[0]))
    else $error("synth");
  a_bypass_mute: assert property (mute_bypass_o [*3] |-> !out_mute_o)
    else $error("bypass");
  a_ofmt_write: assert property (w1 |=> out_fmt_o.fmt == $past(wdata_i[2:0]))
    else $error("out fmt");
  a_ifmt_write: assert property (w2 |=> in_fmt_o.fmt == $past(wdata_i[2:0]))
    else $error("in fmt");
  a_read_zero: assert property (rd_i |=> rdata_o == 16'h0000)
    else $error("read");
  c_back: cover property (w0 ##1 w1);
  c_mute: cover property (out_mute_o);
  c_rdwr: cover property (rd_i ##1 wr_i);
endmodule : adss_regs_chk
bind adss_regs adss_regs_chk u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .lock_lost_i, .non_pcm_i, .out_mute_o, .mute_bypass_o, .crystal_divider_sel_o,
  .prescaler_ratio_sel_o, .clk_cfg_o, .out_fmt_o, .in_fmt_o);
`default_nettype wire

// ### test/tb.sv
// self-checking bench of the system settings register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic clk_i, rst_n_i, wr_i, rd_i, lock_lost_i, non_pcm_i, out_mute_o, mute_bypass_o;
  logic [6:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  adss_pkg::adss_xdiv_t    crystal_divider_sel_o;
  adss_pkg::adss_presc_t   prescaler_ratio_sel_o;
  adss_pkg::adss_clk_cfg_t clk_cfg_o;
  adss_pkg::adss_fmt_cfg_t out_fmt_o, in_fmt_o;
  logic [1:0]  x, p;
  logic        s, c, mb, ll, took;
  logic [2:0]  of, inf;
  logic [31:0] r;
  logic [15:0] rd16;
  logic [61:0] ev;
  logic [61:0] exq [$];
  int          bad_count, total_checks, cyc, seed;
  logic [10:0] pt [4] = '{11'h024, 11'h271, 11'h280, 11'h465};
  logic [4:0]  wt [8] = '{5'h00, 5'h10, 5'h12, 5'h14, 5'h18, 5'h00, 5'h00, 5'h00};
  wire  [61:0] obs = {rdata_o, out_mute_o, mute_bypass_o, crystal_divider_sel_o,
                      prescaler_ratio_sel_o, clk_cfg_o, out_fmt_o, in_fmt_o};
  adss_regs DUT (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .lock_lost_i,
    .non_pcm_i, .out_mute_o, .mute_bypass_o, .crystal_divider_sel_o, .prescaler_ratio_sel_o,
    .clk_cfg_o, .out_fmt_o, .in_fmt_o);
  ////////////////////////////////////////////////////////////////
  function automatic logic [10:0] fx(input logic [2:0] f);
    return {f, wt[f], wt[f] != 5'h00, f == 3'h5, f > 3'h5};
  endfunction : fx
  task automatic op(input logic w, input logic [6:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    if (w && a == 7'h00) {x, p, c, s} = {d[9:8], d[3:0]};
    if (w && a == 7'h01) {mb, of} = {d[8], d[2:0]};
    if (w && a == 7'h02) inf = d[2:0];
    exq.push_back({16'h0000, ll & !mb, mb, x, p, {2'b00, x} + 4'h1,
                   s ? pt[p] : 11'h000, s, c, c, fx(of), fx(inf)});
  endtask : op
  task automatic settle(input logic v);
    @(posedge clk_i);
    {wr_i, rd_i, lock_lost_i, non_pcm_i} <= {2'b00, v, v};
    repeat (8) @(posedge clk_i);
    ll = v;
  endtask : settle
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    took <= wr_i | rd_i;
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end
  always @(negedge clk_i)
    if (took)
    begin
      ev = exq.pop_front();
      `CHK(obs, ev)
    end
  initial
  begin
    {wr_i, rd_i, lock_lost_i, non_pcm_i, rst_n_i, took} = 6'h00;
    {addr_i, wdata_i, x, p, s, c, mb, ll, of, inf} = 37'h00_0000_0000;
    seed = 52;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    op(0, 7'h00, 16'h0000);
    settle(0);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      op(1, 7'h01, {7'h00, i[0], 5'h00, i[2:0]});
      op(1, 7'h02, {13'h0000, 3'h5 - i[2:0]});
      op(0, 7'h01, 16'h0000);
    end
    for (int i = 0; i < 4; i++)
    begin
      op(1, 7'h00, {6'h00, i[1:0], 4'h0, i[1:0], i[1], i[0]});
      op(0, 7'h00, 16'h0000);
    end
    op(1, 7'h03, 16'hffff);
    op(1, 7'h7f, 16'hffff);
    op(0, 7'h7f, 16'h0000);
    settle(0);
    $display("code and map test done");
    settle(1);
    op(0, 7'h00, 16'h0000);
    settle(0);
    op(1, 7'h01, 16'h0000);
    settle(1);
    op(0, 7'h00, 16'h0000);
    settle(0);
    $display("mute test done");
    repeat (80)
    begin
      r = $random(seed);
      rd16 = r[15:0] & ((r[18:17] == 2'b00) ? 16'h030f :
                        (r[18:17] == 2'b01) ? 16'h0107 : 16'h0007);
      if (rd16[2:1] == 2'b11 && r[18:17] != 2'b00)
        rd16[2] = 1'b0;
      op(r[16], {5'h00, r[18:17]}, rd16);
    end
    settle(0);
    $display("random test done");
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    {x, p, s, c, mb, of, inf} = 13'h0000;
    rst_n_i <= 1'b1;
    op(0, 7'h02, 16'h0000);
    settle(0);
    $display("second reset test done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
